// *** hw/rma_proc.sv ***
// processor end: pairing register requests and agent trigger over AXI
`timescale 1ns/10ps
`include "rma_params.svh"
module rma_proc
    import rma_pkg::*;
#(
    parameter int NBUS = 2
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    rma_lbus_if.host         lb,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [11:0] s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp
);
    rma_host_state_e hstate_q;
    logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q;
    logic [3:0]  w_strb_q;
    logic [1:0]  bresp_q, rresp_q;
    logic        wr_fire, wr_hit, rd_fire;
    logic [31:0] req_addr_q, req_data_q, wmask;
    logic [10:0] req_type_q;
    logic [4:0]  ctrl_q;
    logic [2:0]  step_q;
    logic        trig_q, stopped_q, err_q, fault_q, mode_q, valid_q;
    logic [1:0]  bus_q;
    logic [7:0]  msg_cnt_q;
    logic [31:0] last_q, out_addr_q, out_data_q, st_word;
    logic [3:0]  out_type_q;
    logic        go_issue, go_trig, issue_ok, trig_ok;

    assign wmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign wr_hit  = aw_addr_q == `RMA_REG_CTRL ||
                     aw_addr_q == `RMA_REG_REQ_ADDR ||
                     aw_addr_q == `RMA_REG_REQ_DATA ||
                     aw_addr_q == `RMA_REG_REQ_TYPE;
    assign rd_fire = s_axi_arvalid && !rvalid_q;
    assign go_issue = wr_fire && aw_addr_q == `RMA_REG_CTRL &&
                      w_strb_q[0] && w_data_q[`RMA_CTRL_ISSUE];
    assign go_trig  = wr_fire && aw_addr_q == `RMA_REG_CTRL &&
                      w_strb_q[0] && (w_data_q[`RMA_CTRL_RESTART] ||
                      w_data_q[`RMA_CTRL_SEND]);

    // pairing steps go in order and only as physical register requests
    assign issue_ok = hstate_q == RMA_H_IDLE &&
                      req_type_q[3:0] == `RMA_TYPE_PHYS_REQ &&
                      (req_type_q[10:8] == step_q ||
                       req_type_q[10:8] == step_q + 3'h1);
    // the restart may only go once the pair is set up in processor mode
    assign trig_ok  = hstate_q == RMA_H_IDLE && mode_q &&
                      step_q == `RMA_STEP_LAST;

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 12'h0;
            w_hold_q  <= 1'b0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
        end else if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_hold_q) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && !w_hold_q) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RMA_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? `RMA_RESP_OKAY : `RMA_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_addr_q <= 32'h0;
            req_data_q <= 32'h0;
            req_type_q <= {3'h0, 4'h0, `RMA_TYPE_PHYS_REQ};
            ctrl_q     <= 5'h0;
        end else if (wr_fire) begin
            if (aw_addr_q == `RMA_REG_REQ_ADDR) begin
                req_addr_q <= (req_addr_q & ~wmask) | (w_data_q & wmask);
            end else if (aw_addr_q == `RMA_REG_REQ_DATA) begin
                req_data_q <= (req_data_q & ~wmask) | (w_data_q & wmask);
            end else if (aw_addr_q == `RMA_REG_REQ_TYPE) begin
                req_type_q <= (req_type_q & ~wmask[10:0]) |
                              (w_data_q[10:0] & wmask[10:0]);
            end else if (aw_addr_q == `RMA_REG_CTRL && w_strb_q[0]) begin
                ctrl_q <= w_data_q[4:0];
            end
        end
    end

    assign fault_q = ctrl_q[`RMA_CTRL_FAULT];
    assign mode_q  = ctrl_q[`RMA_CTRL_PROC_MODE];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            step_q <= 3'h0;
            err_q  <= 1'b0;
        end else begin
            // a refused request in the clearing write still leaves err set
            if (wr_fire && aw_addr_q == `RMA_REG_CTRL &&
                w_strb_q[0] && w_data_q[`RMA_CTRL_CLR]) begin
                step_q <= 3'h0;
                err_q  <= 1'b0;
            end else if (go_issue && issue_ok) begin
                step_q <= req_type_q[10:8];
            end
            if ((go_issue && !issue_ok) || (go_trig && !trig_ok)) begin
                err_q <= 1'b1;
            end
        end
    end

    // each request goes once on every bus of the module, a restart trigger on bus 0 only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hstate_q   <= RMA_H_IDLE;
            bus_q      <= 2'h0;
            valid_q    <= 1'b0;
            trig_q     <= 1'b0;
            out_addr_q <= 32'h0;
            out_data_q <= 32'h0;
            out_type_q <= 4'h0;
        end else begin
            case (hstate_q)
                RMA_H_IDLE: begin
                    bus_q   <= 2'h0;
                    valid_q <= 1'b0;
                    if (go_issue && issue_ok) begin
                        hstate_q   <= RMA_H_ISSUE;
                        valid_q    <= 1'b1;
                        trig_q     <= 1'b0;
                        out_addr_q <= req_addr_q;
                        out_data_q <= req_data_q;
                        out_type_q <= req_type_q[3:0];
                    end else if (go_trig && trig_ok) begin
                        hstate_q   <= RMA_H_ISSUE;
                        valid_q    <= 1'b1;
                        trig_q     <= w_data_q[`RMA_CTRL_RESTART];
                        out_addr_q <= w_data_q[`RMA_CTRL_RESTART] ?
                                      `RMA_RESTART_ADDR : `RMA_SEND_ADDR;
                        out_data_q <= 32'h0;
                        out_type_q <= `RMA_TYPE_MESSAGE;
                    end
                end
                RMA_H_ISSUE: begin
                    if (trig_q || bus_q == 2'(NBUS - 1)) begin
                        valid_q  <= 1'b0;
                        hstate_q <= trig_q ? RMA_H_STOP : RMA_H_IDLE;
                    end else begin
                        bus_q <= bus_q + 2'h1;
                    end
                end
                RMA_H_STOP:  hstate_q <= RMA_H_IDLE;
                default:     hstate_q <= RMA_H_IDLE;
            endcase
        end
    end

    // stop self right after the trigger; the agent's delay covers it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stopped_q <= 1'b0;
        end else if (hstate_q == RMA_H_STOP) begin
            stopped_q <= 1'b1;
        end else if (lb.msg_ads) begin
            stopped_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            msg_cnt_q <= 8'h0;
            last_q    <= 32'h0;
        end else if (lb.msg_rd) begin
            last_q <= lb.msg_data;
            if (lb.msg_ads) begin
                msg_cnt_q <= msg_cnt_q + 8'h1;
            end
        end
    end

    // reset value marks this processor as the initializer
    logic afault_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            afault_q <= 1'b1;
        end else begin
            afault_q <= fault_q;
        end
    end

    assign st_word = {16'h0, msg_cnt_q, 1'b0, step_q,
                      err_q, stopped_q, lb.agent_busy,
                      hstate_q != RMA_H_IDLE};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `RMA_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= `RMA_RESP_OKAY;
            if (s_axi_araddr[11:2] == `RMA_REG_CTRL >> 2) begin
                rdata_q <= {27'h0, ctrl_q};
            end else if (s_axi_araddr[11:2] == `RMA_REG_REQ_ADDR >> 2) begin
                rdata_q <= req_addr_q;
            end else if (s_axi_araddr[11:2] == `RMA_REG_REQ_DATA >> 2) begin
                rdata_q <= req_data_q;
            end else if (s_axi_araddr[11:2] == `RMA_REG_REQ_TYPE >> 2) begin
                rdata_q <= {21'h0, req_type_q};
            end else if (s_axi_araddr[11:2] == `RMA_REG_STATUS >> 2) begin
                rdata_q <= st_word;
            end else if (s_axi_araddr[11:2] == `RMA_REG_LAST_WORD >> 2) begin
                rdata_q <= last_q;
            end else begin
                rdata_q <= 32'h0;
                rresp_q <= `RMA_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_awready   = !aw_hold_q;
    assign s_axi_wready    = !w_hold_q;
    assign s_axi_bvalid    = bvalid_q;
    assign s_axi_bresp     = bresp_q;
    assign s_axi_arready   = !rvalid_q;
    assign s_axi_rvalid    = rvalid_q;
    assign s_axi_rdata     = rdata_q;
    assign s_axi_rresp     = rresp_q;
    assign lb.req_valid    = valid_q;
    assign lb.req_addr     = out_addr_q;
    assign lb.req_data     = out_data_q;
    assign lb.req_type     = out_type_q;
    assign lb.req_bus      = bus_q;
    assign lb.proc_mode    = mode_q;
    assign lb.access_fault = afault_q;
endmodule // rma_proc

// *** hw/rma_params.svh ***
// constants for the restart message agent and its processor end
`ifndef RMA_PARAMS_SVH
`define RMA_PARAMS_SVH

// local-bus addresses decoded by the agent
`define RMA_RESTART_ADDR   32'hff00_0400
`define RMA_SEND_ADDR      32'hff00_0404
`define RMA_MEM_BASE       32'hff00_0410
`define RMA_MEM_WORDS      4

// message-address word layout
`define RMA_IAC_ID         8'hff
`define RMA_ID_LSB         24
`define RMA_DEST_LSB       16
`define RMA_TYPE_LSB       8
`define RMA_TYPE_MESSAGE   4'h3
`define RMA_TYPE_PHYS_REQ  4'h4

// restart hold-off: 20 us at a 5 ns clock
`define RMA_DELAY_NS       20000
`define RMA_CLK_NS         5
`define RMA_DELAY_CYC      ((`RMA_DELAY_NS + `RMA_CLK_NS - 1) / `RMA_CLK_NS)

// processor-end register map (byte offsets)
`define RMA_REG_CTRL       12'h000
`define RMA_REG_REQ_ADDR   12'h004
`define RMA_REG_REQ_DATA   12'h008
`define RMA_REG_REQ_TYPE   12'h00c
`define RMA_REG_STATUS     12'h010
`define RMA_REG_LAST_WORD  12'h014

// control bits
`define RMA_CTRL_ISSUE     0
`define RMA_CTRL_RESTART   1
`define RMA_CTRL_SEND      2
`define RMA_CTRL_FAULT     3
`define RMA_CTRL_PROC_MODE 4
`define RMA_CTRL_CLR       5

// pairing steps
`define RMA_STEP_LAST      3'h7

`define RMA_RESP_OKAY      2'b00
`define RMA_RESP_SLVERR    2'b10

`endif

// *** hw/rma_pkg.sv ***
// types shared by both ends of the restart message agent
package rma_pkg;
    typedef logic [31:0] rma_word_t;

    typedef enum logic [2:0] {
        RMA_A_IDLE = 3'b000,
        RMA_A_CW   = 3'b001,
        RMA_A_IM0  = 3'b011,
        RMA_A_IM1  = 3'b010,
        RMA_A_IM2  = 3'b110,
        RMA_A_IM3  = 3'b111,
        RMA_A_CK   = 3'b101
    } rma_agent_state_e;

    typedef enum logic [1:0] {
        RMA_H_IDLE  = 2'b00,
        RMA_H_ISSUE = 2'b01,
        RMA_H_STOP  = 2'b11
    } rma_host_state_e;
endpackage

// *** hw/rma_lbus_if.sv ***
// local bus joining the processor end and the restart agent
`timescale 1ns/10ps
interface rma_lbus_if (
    input wire logic aclk
);
    logic        req_valid;
    logic [31:0] req_addr;
    logic [31:0] req_data;
    logic [3:0]  req_type;
    logic [1:0]  req_bus;
    logic        proc_mode;
    logic        access_fault;
    logic        msg_ads;
    logic        msg_rd;
    logic [31:0] msg_data;
    logic        agent_busy;

    modport device (
        input  req_valid, req_addr, req_data, req_type, req_bus,
        input  proc_mode, access_fault,
        output msg_ads, msg_rd, msg_data, agent_busy
    );
    modport host (
        output req_valid, req_addr, req_data, req_type, req_bus,
        output proc_mode, access_fault,
        input  msg_ads, msg_rd, msg_data, agent_busy
    );
endinterface

// *** hw/rma_agent.sv ***
// restart message agent: delayed four-word restart sender with retry
`timescale 1ns/10ps
`include "rma_params.svh"
module rma_agent
    import rma_pkg::*;
#(
    parameter int         DELAY_CYC    = `RMA_DELAY_CYC,
    parameter logic [7:0] PAIR_LOGICAL = 8'h01
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    rma_lbus_if.device      lb,
    output logic            msg_done,
    output logic [7:0]      retry_count
);
    rma_agent_state_e state_q, state_d;
    rma_word_t        mem_q [`RMA_MEM_WORDS];
    logic [12:0]      cnt_q;
    logic [1:0]       idx_q, idx_d;
    logic             restart_q;
    logic             trig_restart, trig_send, in_msg, mem_hit;
    logic             ads_q, rd_q, busy_q, done_q;
    rma_word_t        data_q;
    logic [7:0]       retry_q;

    assign trig_restart = lb.req_valid && lb.proc_mode &&
                          lb.req_addr == `RMA_RESTART_ADDR;
    assign trig_send    = lb.req_valid && lb.proc_mode &&
                          lb.req_addr == `RMA_SEND_ADDR;
    assign mem_hit      = lb.req_valid &&
                          lb.req_addr[31:4] == 28'(`RMA_MEM_BASE >> 4);
    assign in_msg = state_q == RMA_A_IM0 || state_q == RMA_A_IM1 ||
                    state_q == RMA_A_IM2 || state_q == RMA_A_IM3;

    always_comb begin
        state_d = state_q;
        case (state_q)
            RMA_A_IDLE: begin
                if (trig_restart) begin
                    state_d = RMA_A_CW;
                end else if (trig_send) begin
                    state_d = RMA_A_IM0;
                end
            end
            RMA_A_CW:  if (cnt_q == 13'h0) state_d = RMA_A_IM0;
            RMA_A_IM0: state_d = RMA_A_IM1;
            RMA_A_IM1: state_d = restart_q ? RMA_A_IM2 : RMA_A_CK;
            RMA_A_IM2: state_d = RMA_A_IM3;
            RMA_A_IM3: state_d = RMA_A_CK;
            // retry the whole message on a fault, else back to idle
            RMA_A_CK:  state_d = lb.access_fault ? RMA_A_IM0
                                                 : RMA_A_IDLE;
            default:   state_d = RMA_A_IDLE;
        endcase
    end

    // word index wraps at 4 for a restart, at 2 for an ordinary message
    always_comb begin
        idx_d = idx_q;
        if (state_d == RMA_A_IM0) begin
            idx_d = 2'h0;
        end else if (in_msg) begin
            idx_d = restart_q ? idx_q + 2'h1 : {1'b0, ~idx_q[0]};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= RMA_A_IDLE;
            idx_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            idx_q   <= idx_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            restart_q <= 1'b0;
        end else if (state_q == RMA_A_IDLE) begin
            restart_q <= trig_restart;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 13'h0;
        end else if (state_q == RMA_A_IDLE) begin
            cnt_q <= 13'(DELAY_CYC - 1);
        end else if (state_q == RMA_A_CW && cnt_q != 13'h0) begin
            cnt_q <= cnt_q - 13'h1;
        end
    end

    // stored message; word 0 comes up as the restart message address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_q[0] <= (32'(`RMA_IAC_ID)        << `RMA_ID_LSB)   |
                        (32'(PAIR_LOGICAL)       << `RMA_DEST_LSB) |
                        (32'(`RMA_TYPE_MESSAGE)  << `RMA_TYPE_LSB);
            mem_q[1] <= 32'h0;
            mem_q[2] <= 32'h0;
            mem_q[3] <= 32'h0;
        end else if (mem_hit) begin
            mem_q[lb.req_addr[3:2]] <= lb.req_data;
        end
    end

    // words leave in stored order: address, message, table, control block
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ads_q  <= 1'b0;
            rd_q   <= 1'b0;
            data_q <= 32'h0;
            busy_q <= 1'b0;
        end else begin
            ads_q  <= state_d == RMA_A_IM0;
            rd_q   <= state_d == RMA_A_IM0 || state_d == RMA_A_IM1 ||
                      state_d == RMA_A_IM2 || state_d == RMA_A_IM3;
            data_q <= mem_q[idx_d];
            busy_q <= state_d != RMA_A_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_q  <= 1'b0;
            retry_q <= 8'h0;
        end else begin
            done_q <= state_q == RMA_A_CK && !lb.access_fault;
            if (state_q == RMA_A_CK && lb.access_fault &&
                retry_q != 8'hff) begin
                retry_q <= retry_q + 8'h1;
            end
        end
    end

    assign lb.msg_ads    = ads_q;
    assign lb.msg_rd     = rd_q;
    assign lb.msg_data   = data_q;
    assign lb.agent_busy = busy_q;
    assign msg_done      = done_q;
    assign retry_count   = retry_q;
endmodule // rma_agent

// *** sim/rma_lbus_checker.sv ***
// concurrent checks on the local bus between processor end and agent
`timescale 1ns/10ps
`include "rma_params.svh"
module rma_lbus_checker #(
    parameter int         DELAY_CYC    = 8,
    parameter logic [7:0] PAIR_LOGICAL = 8'h01
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        req_valid,
    input wire logic [31:0] req_addr,
    input wire logic [3:0]  req_type,
    input wire logic [1:0]  req_bus,
    input wire logic        proc_mode,
    input wire logic        access_fault,
    input wire logic        msg_ads,
    input wire logic        msg_rd,
    input wire logic [31:0] msg_data,
    input wire logic        agent_busy
);
    localparam int DLY_LO = DELAY_CYC;
    localparam int DLY_HI = DELAY_CYC + 4;
    logic trig_r;
    logic trig_s;
    logic restart_q;

    assign trig_r = req_valid && proc_mode && !agent_busy
                    && req_addr == `RMA_RESTART_ADDR;
    assign trig_s = req_valid && proc_mode && !agent_busy
                    && req_addr == `RMA_SEND_ADDR;

    // remembers which kind of message the agent is sending
    always_ff @(posedge aclk) begin
        if (!aresetn)
            restart_q <= 1'b0;
        else if (trig_r)
            restart_q <= 1'b1;
        else if (trig_s)
            restart_q <= 1'b0;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_SEND_START: assert property (
        trig_s |-> ##1 msg_ads) else $error("send start late");
    AST_RESTART_HOLD: assert property (
        trig_r |-> ##1 !msg_rd [*8]) else $error("restart too early");
    AST_RESTART_WIN: assert property (
        trig_r |-> ##[DLY_LO:DLY_HI] msg_ads) else $error("restart late");
    AST_RESTART_WORDS: assert property (
        msg_ads && restart_q |-> msg_rd [*4] ##1 !msg_rd)
        else $error("restart word count wrong");
    AST_SEND_WORDS: assert property (
        msg_ads && !restart_q |-> msg_rd [*2] ##1 !msg_rd)
        else $error("send word count wrong");
    AST_ADDR_FMT: assert property (
        msg_ads |-> msg_rd && msg_data[31:24] == `RMA_IAC_ID
        && msg_data[23:16] == PAIR_LOGICAL
        && msg_data[11:8] == `RMA_TYPE_MESSAGE)
        else $error("message address word wrong");
    AST_RETRY: assert property (
        $fell(msg_rd) && access_fault |-> ##1 msg_ads)
        else $error("no resend after fault");
    AST_CLEAN_IDLE: assert property (
        $fell(msg_rd) && !access_fault |-> ##1 !msg_ads ##1 !agent_busy)
        else $error("agent not idle after clean message");
    AST_BUS_COPIES: assert property (
        $rose(req_valid) && req_type == `RMA_TYPE_PHYS_REQ
        && !(req_addr inside {`RMA_RESTART_ADDR, `RMA_SEND_ADDR})
        |-> req_bus == 2'h0 ##1 req_valid && req_bus == 2'h1
        && $stable(req_addr)) else $error("request not on both buses");
endmodule // rma_lbus_checker

// *** sim/restart_message_agent_tb_top.sv ***
// self-checking bench for the processor end and restart agent pair
`timescale 1ns/10ps
`include "rma_params.svh"
module restart_message_agent_tb_top;
    import rma_pkg::*;
    logic        aclk;
    logic        aresetn;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, msg_done;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_d;
    logic [1:0]  bresp, rresp;
    logic [7:0]  retry_count;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          n_done = 0;

    always #2.5 aclk = ~aclk;

    rma_lbus_if u_rma_lbus_if (.aclk(aclk));
    rma_agent #(.DELAY_CYC(8)) u_rma_agent (.aclk(aclk), .aresetn(aresetn),
        .lb(u_rma_lbus_if), .msg_done(msg_done), .retry_count(retry_count));
    rma_proc #(.NBUS(2)) u_rma_proc (.aclk(aclk), .aresetn(aresetn),
        .lb(u_rma_lbus_if), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
    rma_lbus_checker #(.DELAY_CYC(8)) u_rma_lbus_checker (.aclk(aclk),
        .aresetn(aresetn), .req_valid(u_rma_lbus_if.req_valid),
        .req_addr(u_rma_lbus_if.req_addr), .req_type(u_rma_lbus_if.req_type),
        .req_bus(u_rma_lbus_if.req_bus), .proc_mode(u_rma_lbus_if.proc_mode),
        .access_fault(u_rma_lbus_if.access_fault),
        .msg_ads(u_rma_lbus_if.msg_ads), .msg_rd(u_rma_lbus_if.msg_rd),
        .msg_data(u_rma_lbus_if.msg_data),
        .agent_busy(u_rma_lbus_if.agent_busy));

    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd_raw(input logic [11:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_d = rdata;
        rready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] e, input logic [1:0] er);
        rd_raw(a);
        chk(rd_d & m, e);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    // polls until both ends report idle, bounded
    task automatic idle_wait;
        int k;
        k = 0;
        do begin
            rd_raw(`RMA_REG_STATUS);
            k++;
        end while (rd_d[1:0] !== 2'b00 && k < 100);
        chk({31'h0, k < 100}, 32'h1);
    endtask

    // counts clean completions reported by the agent
    always @(posedge aclk) begin
        if (msg_done === 1'b1) n_done++;
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            wrap_up();
        end
    end

    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h100, 32'hffff_ffff, 32'h0, `RMA_RESP_SLVERR);
        wr(`RMA_REG_STATUS, 32'h0, `RMA_RESP_SLVERR);
        wr(`RMA_REG_CTRL, 32'h10, `RMA_RESP_OKAY);
        wr(`RMA_REG_CTRL, 32'h14, `RMA_RESP_OKAY);
        rd(`RMA_REG_STATUS, 32'h0a, 32'h08, `RMA_RESP_OKAY);
        wr(`RMA_REG_CTRL, 32'h30, `RMA_RESP_OKAY);
        wr(`RMA_REG_REQ_TYPE, 32'h100, `RMA_RESP_OKAY);
        wr(`RMA_REG_CTRL, 32'h11, `RMA_RESP_OKAY);
        rd(`RMA_REG_STATUS, 32'h08, 32'h08, `RMA_RESP_OKAY);
        wr(`RMA_REG_CTRL, 32'h30, `RMA_RESP_OKAY);
        rd(`RMA_REG_STATUS, 32'h78, 32'h0, `RMA_RESP_OKAY);
        // steps 1..3 also load stored message words 1..3
        for (int s = 1; s <= 7; s++) begin
            wr(`RMA_REG_REQ_ADDR, (s <= 3) ? `RMA_MEM_BASE + 32'(4 * s)
               : 32'hff00_0100 + 32'(s), `RMA_RESP_OKAY);
            wr(`RMA_REG_REQ_DATA, 32'h5a00_0000 + 32'(s), `RMA_RESP_OKAY);
            wr(`RMA_REG_REQ_TYPE, 32'(s << 8) | 32'h4, `RMA_RESP_OKAY);
            wr(`RMA_REG_CTRL, 32'h11, `RMA_RESP_OKAY);
        end
        rd(`RMA_REG_STATUS, 32'h7f, 32'h70, `RMA_RESP_OKAY);
        wr(`RMA_REG_CTRL, 32'h14, `RMA_RESP_OKAY);
        idle_wait();
        rd(`RMA_REG_LAST_WORD, '1, 32'h5a00_0001, `RMA_RESP_OKAY);
        wr(`RMA_REG_CTRL, 32'h12, `RMA_RESP_OKAY);
        repeat (2) @(posedge aclk);
        rd(`RMA_REG_STATUS, 32'h06, 32'h06, `RMA_RESP_OKAY);
        idle_wait();
        rd(`RMA_REG_LAST_WORD, '1, 32'h5a00_0003, `RMA_RESP_OKAY);
        rd(`RMA_REG_STATUS, 32'hff04, 32'h0200, `RMA_RESP_OKAY);
        chk({24'h0, retry_count}, 32'h0);
        wr(`RMA_REG_CTRL, 32'h1a, `RMA_RESP_OKAY);
        // let a few attempts fail before lifting the fault
        repeat (40) @(posedge aclk);
        wr(`RMA_REG_CTRL, 32'h10, `RMA_RESP_OKAY);
        idle_wait();
        chk({31'h0, retry_count != 8'h0}, 32'h1);
        rd(`RMA_REG_LAST_WORD, '1, 32'h5a00_0003, `RMA_RESP_OKAY);
        chk(32'(n_done), 32'h3);
        wrap_up();
    end
endmodule // restart_message_agent_tb_top
